// file: media_status_map.svh
// offsets, fields, reset values and timing counts of the media converter status block
`ifndef MEDIA_STATUS_MAP_SVH
`define MEDIA_STATUS_MAP_SVH
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_MASK 12'h00c
`define CTRL_ESM_LSB 0
`define CTRL_SPEED_LSB 4
`define CTRL_RESET 32'h0000_0001
`define IRQ_W 4
`define IRQ_MOVED 0
`define IRQ_INVALID 1
`define IRQ_FAULT 2
`define IRQ_LINKUP 3
`define SW_LAST_VALID 4'h3
`define SPEED_100 2'h1
`define CLK_KHZ 25000
`define CLK_PERIOD_NS 40
`define LATENCY_NS 1000
`define LATENCY_CYC ((`LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_MS 50
`define TICK_CYC (`TICK_MS * `CLK_KHZ)
`define TICKS_PER_FRAME 5'h18
`define FLASH_TICKS 5'h04
`endif

// file: media_status_pkg.sv
// types of the media converter status block
package media_status_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } beat_type;
    typedef enum logic [1:0] {
        MODE_COPPER_TO_TRX = 2'b00,
        MODE_TRX_TO_COPPER = 2'b01,
        MODE_TRX_TO_TRX = 2'b10,
        MODE_ETHERNET = 2'b11
    } mode_type;
    typedef enum logic [1:0] {
        SUP_CAPTURE = 2'b00,
        SUP_INVALID = 2'b01,
        SUP_RUN = 2'b10,
        SUP_MOVED = 2'b11
    } sup_type;
    typedef enum logic [3:0] {
        ESM_INIT = 4'h1,
        ESM_PREOP = 4'h2,
        ESM_BOOT = 4'h3,
        ESM_SAFEOP = 4'h4,
        ESM_OP = 4'h8
    } esm_type;
endpackage : media_status_pkg

// file: media_converter_status.sv
// status, mode supervision and forwarding of the three-port media converter
//
// How it works
// RULE1: state INIT keeps the run indicator dark.
// RULE2: state PREOP gives a single green flash each frame.
// RULE3: state SAFEOP blinks the run indicator green.
// RULE4: state OP lights the run indicator steady green.
// RULE5: state BOOTSTRAP flickers green, faster than the blink.
// RULE6: switch moved in EtherCAT mode gives steady orange until reset.
// RULE7: switch moved in Ethernet mode gives steady red until reset.
// RULE8: invalid switch at power-on alternates red and green until valid.
// RULE9: copper indicator dark without link, green when linked, blinking on traffic.
// RULE10: switch setting selects forwarding direction or Ethernet operation.
// RULE11: every port forwards with a fixed delay of about one microsecond.
// RULE12: a port with link fault is closed and its traffic looped onward.
// RULE13: EtherCAT mode forces 100 Mbit/s; Ethernet mode takes the set speed.
// RULE14: switch is latched once after reset; later moves only flag mismatch (here a move also stops forwarding on every port).
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "media_status_map.svh"

module media_converter_status
    import media_status_pkg::*;
#(
    parameter int unsigned TICK_CYC = `TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] rotary_switch,
    input wire logic [2:0] port_link_up,
    input wire logic copper_activity,
    input wire beat_type copper_port_rx,
    input wire beat_type first_transceiver_port_rx,
    input wire beat_type second_transceiver_port_rx,
    output beat_type copper_port_tx,
    output beat_type first_transceiver_port_tx,
    output beat_type second_transceiver_port_tx,
    output logic [5:0] port_speed,
    output logic run_green,
    output logic run_red,
    output logic link_act_green,
    output logic irq
);
    localparam int unsigned LAT = `LATENCY_CYC;

    // ************************************
    // apb slave and registers
    // ************************************
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic [`IRQ_W-1:0] irq_status_reg, irq_status_next, irq_mask_reg, irq_mask_next;
    logic irq_reg, irq_next;
    logic [`IRQ_W-1:0] events;
    logic wr_en, hit;
    logic [31:0] status_word;
    sup_type sup_reg, sup_next;
    mode_type mode_reg, mode_next;
    logic [2:0] link_prev_reg;

    assign wr_en = psel && penable && pready_reg && pwrite;

    always_comb begin
        ctrl_next = ctrl_reg;
        irq_mask_next = irq_mask_reg;
        irq_status_next = irq_status_reg;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        hit = 1'b1;
        status_word = {24'h0, port_link_up, 1'b0, sup_reg, mode_reg};
        // a setup pending answer comes one cycle into the access phase
        if (psel && penable && !pready_reg) begin
            pready_next = 1'b1;
            case (paddr)
                `REG_CTRL: prdata_next = ctrl_reg;
                `REG_STATUS: prdata_next = status_word;
                `REG_IRQ_STATUS: prdata_next = {28'h0, irq_status_reg};
                `REG_IRQ_MASK: prdata_next = {28'h0, irq_mask_reg};
                default: begin
                    prdata_next = 32'h0;
                    hit = 1'b0;
                end
            endcase
            pslverr_next = !hit;
        end
        if (wr_en) begin
            case (paddr)
                `REG_CTRL: ctrl_next = {26'h0, pwdata[5:0]};
                `REG_IRQ_MASK: irq_mask_next = pwdata[`IRQ_W-1:0];
                `REG_IRQ_STATUS: irq_status_next = irq_status_reg & ~pwdata[`IRQ_W-1:0];
                default: ctrl_next = ctrl_reg;
            endcase
        end
        // an event in the clearing cycle survives
        irq_status_next = irq_status_next | events;
        irq_next = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
            irq_mask_reg <= 4'h0;
            irq_status_reg <= 4'h0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            irq_mask_reg <= irq_mask_next;
            irq_status_reg <= irq_status_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    // ************************************
    // rotary switch supervision
    // ************************************
    logic sw_valid;
    assign sw_valid = rotary_switch <= `SW_LAST_VALID;

    always_comb begin
        sup_next = sup_reg;
        mode_next = mode_reg;
        events = 4'h0;
        events[`IRQ_FAULT] = |(link_prev_reg & ~port_link_up);
        events[`IRQ_LINKUP] = port_link_up[0] && !link_prev_reg[0];
        case (sup_reg)
            // RULE14: latch once after reset
            SUP_CAPTURE: begin
                if (sw_valid) begin
                    mode_next = mode_type'(rotary_switch[1:0]);
                    sup_next = SUP_RUN;
                end else begin
                    sup_next = SUP_INVALID;
                    events[`IRQ_INVALID] = 1'b1;
                end
            end
            // RULE8: wait for valid setting
            SUP_INVALID: begin
                if (sw_valid) begin
                    mode_next = mode_type'(rotary_switch[1:0]);
                    sup_next = SUP_RUN;
                end
            end
            // RULE14: a move flags mismatch; SUP_MOVED also stops forwarding
            SUP_RUN: begin
                if (rotary_switch != {2'b00, mode_reg}) begin
                    sup_next = SUP_MOVED;
                    events[`IRQ_MOVED] = 1'b1;
                end
            end
            SUP_MOVED: sup_next = SUP_MOVED;
            default: sup_next = SUP_CAPTURE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_reg <= SUP_CAPTURE;
            mode_reg <= MODE_COPPER_TO_TRX;
            link_prev_reg <= 3'b000;
        end else begin
            sup_reg <= sup_next;
            mode_reg <= mode_next;
            link_prev_reg <= port_link_up;
        end
    end

    // ************************************
    // indicator timing
    // ************************************
    logic [31:0] tick_cnt_reg, tick_cnt_next;
    logic [4:0] tick_idx_reg, tick_idx_next;
    logic act_reg, act_next;
    logic run_green_reg, run_green_next, run_red_reg, run_red_next;
    logic la_reg, la_next;
    logic blink_ph, flick_ph, flash_ph;

    assign flick_ph = tick_idx_reg[0];
    assign blink_ph = tick_idx_reg[2];
    assign flash_ph = tick_idx_reg < `FLASH_TICKS;

    always_comb begin
        tick_cnt_next = tick_cnt_reg + 32'h1;
        tick_idx_next = tick_idx_reg;
        if (tick_cnt_reg >= TICK_CYC - 1) begin
            tick_cnt_next = 32'h0;
            tick_idx_next = (tick_idx_reg == `TICKS_PER_FRAME - 5'h1) ? 5'h0 : tick_idx_reg + 5'h1;
        end
        // RULE9: traffic is held until a blink period ends
        act_next = act_reg;
        if (tick_cnt_next == 32'h0 && tick_idx_next[2:0] == 3'h0) begin
            act_next = 1'b0;
        end
        act_next = act_next | copper_activity;
        la_next = !port_link_up[0] ? 1'b0 : (act_reg ? blink_ph : 1'b1);
        run_green_next = 1'b0;
        run_red_next = 1'b0;
        case (sup_reg)
            // RULE8: red and green alternate
            SUP_INVALID: begin
                run_red_next = blink_ph;
                run_green_next = !blink_ph;
            end
            // RULE6: orange, RULE7: red
            SUP_MOVED: begin
                run_red_next = 1'b1;
                run_green_next = mode_reg != MODE_ETHERNET;
            end
            SUP_RUN: begin
                case (esm_type'(ctrl_reg[`CTRL_ESM_LSB +: 4]))
                    // RULE1: init dark
                    ESM_INIT: run_green_next = 1'b0;
                    // RULE2: single flash
                    ESM_PREOP: run_green_next = flash_ph;
                    // RULE3: blinking
                    ESM_SAFEOP: run_green_next = blink_ph;
                    // RULE4: steady green
                    ESM_OP: run_green_next = 1'b1;
                    // RULE5: flicker
                    ESM_BOOT: run_green_next = flick_ph;
                    default: run_green_next = 1'b0;
                endcase
            end
            default: run_green_next = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0;
            tick_idx_reg <= 5'h0;
            act_reg <= 1'b0;
            la_reg <= 1'b0;
            run_green_reg <= 1'b0;
            run_red_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_idx_reg <= tick_idx_next;
            act_reg <= act_next;
            la_reg <= la_next;
            run_green_reg <= run_green_next;
            run_red_reg <= run_red_next;
        end
    end

    // ************************************
    // forwarding
    // ************************************
    // ring successor of each port; index 0 copper, 1 first, 2 second
    function automatic logic [1:0] succ(input mode_type m, input logic [1:0] p);
        logic [1:0] r;
        r = 2'd0;
        case (m)
            MODE_TRX_TO_COPPER: r = (p == 2'd0) ? 2'd2 : ((p == 2'd2) ? 2'd1 : 2'd0);
            MODE_TRX_TO_TRX: r = (p == 2'd1) ? 2'd2 : ((p == 2'd2) ? 2'd0 : 2'd1);
            default: r = (p == 2'd2) ? 2'd0 : p + 2'd1;
        endcase
        return r;
    endfunction : succ

    beat_type rx [3];
    beat_type fwd [3];
    logic [1:0] dest [3];
    logic [1:0] speed_reg [3];
    logic [1:0] speed_next [3];
    assign rx[0] = copper_port_rx;
    assign rx[1] = first_transceiver_port_rx;
    assign rx[2] = second_transceiver_port_rx;

    always_comb begin
        for (int p = 0; p < 3; p++) begin
            // RULE10: direction from latched mode
            dest[p] = succ(mode_reg, 2'(p));
            // RULE12: skip a closed port, else loop back
            if (!port_link_up[dest[p]]) begin
                dest[p] = succ(mode_reg, dest[p]);
            end
            if (!port_link_up[dest[p]]) begin
                dest[p] = 2'(p);
            end
        end
        for (int o = 0; o < 3; o++) begin
            fwd[o] = '0;
            for (int p = 0; p < 3; p++) begin
                if (dest[p] == 2'(o) && port_link_up[p] && sup_reg == SUP_RUN) begin
                    fwd[o] = fwd[o] | rx[p];
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_port
            beat_type dly_reg [LAT];
            beat_type dly_next [LAT];
            always_comb begin
                // RULE11: fixed delay line
                dly_next[0] = fwd[g];
                for (int i = 1; i < LAT; i++) begin
                    dly_next[i] = dly_reg[i-1];
                end
                // RULE13: EtherCAT pinned at 100 Mbit/s
                speed_next[g] = (mode_reg == MODE_ETHERNET) ? ctrl_reg[`CTRL_SPEED_LSB +: 2]
                                                           : `SPEED_100;
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    for (int i = 0; i < LAT; i++) begin
                        dly_reg[i] <= '0;
                    end
                    speed_reg[g] <= `SPEED_100;
                end else begin
                    dly_reg <= dly_next;
                    speed_reg[g] <= speed_next[g];
                end
            end
        end
    endgenerate

    assign copper_port_tx = g_port[0].dly_reg[LAT-1];
    assign first_transceiver_port_tx = g_port[1].dly_reg[LAT-1];
    assign second_transceiver_port_tx = g_port[2].dly_reg[LAT-1];
    assign port_speed = {speed_reg[2], speed_reg[1], speed_reg[0]};
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign run_green = run_green_reg;
    assign run_red = run_red_reg;
    assign link_act_green = la_reg;
endmodule : media_converter_status

// file: media_status_checker.sv
// concurrent checks on the ports of the media converter status block
`timescale 1ns/1ns
`include "media_status_map.svh"
module media_status_checker
    import media_status_pkg::*;
#(
    parameter int unsigned TICK_CYC = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] rotary_switch,
    input wire logic [2:0] port_link_up,
    input wire beat_type copper_port_rx,
    input wire beat_type first_transceiver_port_rx,
    input wire beat_type second_transceiver_port_rx,
    input wire beat_type first_transceiver_port_tx,
    input wire logic [5:0] port_speed,
    input wire logic run_green,
    input wire logic run_red
);
    logic [1:0] lat;
    logic lat_ok;
    logic moved;
    logic [2:0] age;
    wire any_rx = copper_port_rx.valid | first_transceiver_port_rx.valid
        | second_transceiver_port_rx.valid;
    // own copy of the mode latch, so a design that relatches is caught
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat <= 2'h0;
            lat_ok <= 1'b0;
            moved <= 1'b0;
            age <= 3'h0;
        end else if (!lat_ok && rotary_switch < 4'h4) begin
            lat <= rotary_switch[1:0];
            lat_ok <= 1'b1;
            age <= 3'h0;
        end else if (lat_ok && !moved && rotary_switch != {2'h0, lat}) begin
            moved <= 1'b1;
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end
    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_answer;
        s_setup ##1 s_access |-> !pready ##1 pready;
    endproperty
    a_answer: assert property (p_answer) // bus timing
        else $error("answer not in second access cycle");
    property p_err;
        pready |-> pslverr == (paddr > `REG_IRQ_MASK);
    endproperty
    a_err: assert property (p_err) // bus refusal
        else $error("error flag wrong for address");
    property p_fwd;
        first_transceiver_port_tx.valid |-> $past(any_rx, 25);
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("beat without source beat 25 cycles before");
    property p_ring;
        lat_ok && !moved && lat == 2'h0 && &port_link_up && copper_port_rx.valid
            |-> ##25 first_transceiver_port_tx == $past(copper_port_rx, 25);
    endproperty
    a_ring: assert property (p_ring)
        else $error("copper beat not forwarded");
    property p_orange;
        moved && age > 3'h3 && lat != 2'h3 |-> run_green && run_red;
    endproperty
    a_orange: assert property (p_orange)
        else $error("moved switch not orange");
    property p_red;
        moved && age > 3'h3 && lat == 2'h3 |-> run_red && !run_green;
    endproperty
    a_red: assert property (p_red)
        else $error("moved switch not red");
    property p_invalid;
        !lat_ok && age > 3'h3 |-> run_red != run_green;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("invalid switch not alternating");
    property p_speed;
        lat_ok && lat != 2'h3 |-> port_speed == 6'h15;
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed not forced in fieldbus mode");
endmodule : media_status_checker

bind media_converter_status media_status_checker #(.TICK_CYC(TICK_CYC))
    i_media_status_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .rotary_switch(rotary_switch),
    .port_link_up(port_link_up), .copper_port_rx(copper_port_rx),
    .first_transceiver_port_rx(first_transceiver_port_rx),
    .second_transceiver_port_rx(second_transceiver_port_rx),
    .first_transceiver_port_tx(first_transceiver_port_tx), .port_speed(port_speed),
    .run_green(run_green), .run_red(run_red));

// file: media_neighbour_model.sv
// neighbouring network devices feeding the receive side of each port
`timescale 1ns/1ns
module media_neighbour_model
    import media_status_pkg::*;
(
    input wire logic pclk,
    input wire logic go,
    input wire logic [1:0] port,
    input wire logic [7:0] byte_in,
    output beat_type rx [3],
    output logic act
);
    initial begin
        foreach (rx[i]) rx[i] = 9'h0a5;
        act = 1'b0;
    end
    // idle data keeps toggling so a stale byte never looks fresh
    always @(posedge pclk) begin
        foreach (rx[i]) begin
            rx[i].valid <= go && port == 2'(i);
            rx[i].data <= (go && port == 2'(i)) ? byte_in : ~rx[i].data;
        end
        act <= go && port == 2'h0;
    end
endmodule : media_neighbour_model

// file: media_converter_status_bench.sv
// self-checking bench of the media converter status block
`timescale 1ns/1ns
`include "media_status_map.svh"
`define check(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module media_converter_status_bench
    import media_status_pkg::*;
;
    localparam int T = 4;
    int n_mismatch = 0;
    int n_tests = 0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic [3:0] sw = 4'h0;
    logic [2:0] link = 3'h7;
    logic go = 1'b0;
    logic [1:0] port = 2'h0;
    logic [7:0] byte_in = 8'h00;
    logic act;
    beat_type rx [3];
    beat_type tx [3];
    logic [5:0] speed;
    logic green;
    logic red;
    logic lamp;
    logic irq;
    always #20 pclk = ~pclk;
    media_neighbour_model i_media_neighbour_model (.pclk(pclk), .go(go), .port(port),
        .byte_in(byte_in), .rx(rx), .act(act));
    media_converter_status #(.TICK_CYC(T)) i_media_converter_status (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rotary_switch(sw), .port_link_up(link), .copper_activity(act),
        .copper_port_rx(rx[0]), .first_transceiver_port_rx(rx[1]),
        .second_transceiver_port_rx(rx[2]), .copper_port_tx(tx[0]),
        .first_transceiver_port_tx(tx[1]), .second_transceiver_port_tx(tx[2]),
        .port_speed(speed), .run_green(green), .run_red(red), .link_act_green(lamp), .irq(irq));
    task automatic print_verdict;
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no own limit: only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic boot(input logic [3:0] s);
        presetn <= 1'b0;
        sw <= s;
        link <= 3'h7;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : boot
    function automatic int dest(input int m, input int s, input logic [2:0] up);
        int nx [3];
        int d;
        nx = '{1, 2, 0};
        if (m == 1) nx = '{2, 0, 1};
        d = nx[s];
        if (up[d] !== 1'b1) d = nx[d];
        if (up[d] !== 1'b1) d = s;
        return d;
    endfunction : dest
    function automatic void lamp_exp(input esm_type e, output int on, output int ed);
        on = (e == ESM_OP) ? 24 * T : (e == ESM_PREOP) ? 4 * T : (e == ESM_INIT) ? 0 : 12 * T;
        ed = (e == ESM_PREOP) ? 2 : (e == ESM_SAFEOP) ? 6 : (e == ESM_BOOT) ? 24 : 0;
    endfunction : lamp_exp
    task automatic send(input int src, input int dst);
        logic [7:0] b;
        beat_type t;
        int k;
        b = 8'($urandom);
        port <= 2'(src);
        byte_in <= b;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (k = 1; k < 40; k++) begin
            @(posedge pclk);
            #1;
            t = tx[dst];
            if (t.valid === 1'b1) break;
        end
        @(posedge pclk);
        `check("delay", 25, k)
        `check("beat", {1'b1, b}, t)
    endtask : send
    task automatic watch(input bit sel, input int n, output int on, output int ed);
        logic p;
        // start from the settled value, so the window spans whole frames
        #1;
        p = sel ? lamp : green;
        on = 0;
        ed = 0;
        repeat (n) begin
            @(posedge pclk);
            #1;
            if ((sel ? lamp : green) === 1'b1) on++;
            if ((sel ? lamp : green) !== p) ed++;
            p = sel ? lamp : green;
        end
        @(posedge pclk);
    endtask : watch
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
    // ********************
    // tests
    // ********************
    initial begin
        int on;
        int ed;
        int m;
        int s;
        logic [1:0] k;
        esm_type es [5];
        es = '{ESM_INIT, ESM_PREOP, ESM_SAFEOP, ESM_OP, ESM_BOOT};
        void'($urandom(51));
        for (m = 0; m < 4; m++) begin
            boot(4'(m));
            apb(1'b0, `REG_STATUS, 32'h0);
            `check("status", 32'he8 | m, rd)
            s = $urandom % 3;
            send(0, dest(m, 0, 3'h7));
            send(s, dest(m, s, 3'h7));
        end
        k = 2'($urandom);
        apb(1'b1, `REG_CTRL, {26'h0, k, 4'h1});
        // speed register follows the control register one edge later
        @(posedge pclk);
        `check("speed", {3{k}}, speed)
        link <= 3'b101;
        send(0, dest(3, 0, 3'b101));
        link <= 3'b001;
        send(0, dest(3, 0, 3'b001));
        apb(1'b1, `REG_IRQ_STATUS, 32'hf);
        apb(1'b1, 12'h014, 32'hf);
        apb(1'b0, `REG_IRQ_MASK, 32'h0);
        `check("unmapped write", 32'h0, rd)
        link <= 3'b110;
        repeat (3) @(posedge pclk);
        apb(1'b0, `REG_IRQ_STATUS, 32'h0);
        `check("fault event", 32'h4, rd)
        `check("masked irq", 1'b0, irq)
        apb(1'b1, `REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge pclk);
        `check("irq", 1'b1, irq)
        apb(1'b1, `REG_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge pclk);
        `check("cleared irq", 1'b0, irq)
        apb(1'b0, 12'h010, 32'h0);
        `check("unmapped", 33'h100000000, {err, rd})
        boot(4'h0);
        apb(1'b0, `REG_CTRL, 32'h0);
        `check("ctrl reset", `CTRL_RESET, rd)
        apb(1'b1, `REG_CTRL, 32'h21);
        `check("speed", 6'h15, speed)
        foreach (es[i]) begin
            apb(1'b1, `REG_CTRL, {28'h0, es[i]});
            repeat (8) @(posedge pclk);
            watch(1'b0, 24 * T, on, ed);
            lamp_exp(es[i], m, s);
            `check("run lit", m, on)
            `check("run toggles", s, ed)
        end
        sw <= 4'h2;
        repeat (6) @(posedge pclk);
        `check("orange", 2'b11, {green, red})
        apb(1'b0, `REG_STATUS, 32'h0);
        `check("moved status", 32'hec, rd)
        boot(4'h3);
        sw <= 4'h0;
        repeat (6) @(posedge pclk);
        `check("red", 2'b01, {green, red})
        boot(4'h4 + 4'($urandom % 12));
        repeat (8) @(posedge pclk);
        watch(1'b0, 24 * T, on, ed);
        `check("invalid blink", 12 * T + 6, on + ed)
        sw <= 4'h2;
        repeat (4) @(posedge pclk);
        apb(1'b0, `REG_STATUS, 32'h0);
        `check("valid again", 32'hea, rd)
        link <= 3'h6;
        repeat (9 * T + 4) @(posedge pclk);
        watch(1'b1, 16, on, ed);
        `check("no link", 0, on)
        link <= 3'h1;
        repeat (9 * T + 4) @(posedge pclk);
        watch(1'b1, 16, on, ed);
        `check("linked", 16, on)
        fork
            watch(1'b1, 64, on, ed);
            repeat (64) @(posedge pclk) go <= ~go;
        join
        go <= 1'b0;
        `check("traffic", 1'b1, ed >= 3)
        print_verdict();
    end
endmodule : media_converter_status_bench
